// ### design/srt_pkg.sv
// Constants, types and helper functions for the ramp and time-tag controller
// Contract
// - Time counters step on the 100 kHz reference; second pulse aligned to it.
// - External station time loads all time digits at once.
// - Processor presets the time in four word writes, assembled then loaded.
// - Internal clock counts 10 us steps, up to 999 days.
// - Internal mode ignores external time and presents the internal counter.
// - Loss of external time hands over to the internal counter seamlessly.
// - In external mode the internal counter keeps following station time.
// - Time tag holds a full-resolution time plus a function code.
// - Tag compared with all clock digits continuously; match runs the function.
// - A tag match raises an interrupt request to the processor.
// - Three writable data registers: initial value and two increments.
// - Start, stop, fixed frequency, positive and negative ramps supported.
// - Load command moves the initial value to stage one next 10 us.
// - Add: stage one to stage two, sum of stage one and increment to stage one.
// - Once started, a new value reaches the output every 10 us until stop.
// - Synthesizer cycles counted; count offered to the processor every 100 ms.
// - Cycle counter is synchronous and handles inputs up to 51 MHz.
// - Three retriggerable one-shots flag stopped or slow 100k, 1M, 5M clocks.
// - Status shows synthesizer power and the unlocked latch.
// - Lock loss sets a sticky flag cleared by reading status.
// - Three contact outputs: ready, phase in lock, power present.
// - Register address decoded into per-register read and write enables.
// - Tag match runs one of seven load, select, run, stop and step actions.
// - Nine-digit BCD cycle counter wraps, latched every 100 ms.
// - Real-time clock raises an interrupt at every 100 ms boundary.
// - Inactive increment preloaded; switched to on a rate change command.
package srt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NDIG          = 14;
  localparam int unsigned TIME_W        = 56;
  localparam int unsigned CYC_W         = 36;
  // Clock monitors trip after twice the nominal period without an edge
  localparam int unsigned MON100K_NS  = 10000;
  localparam int unsigned MON1M_NS    = 1000;
  localparam int unsigned MON5M_NS    = 200;
  localparam logic [11:0] MON100K_CYC = 12'(2 * MON100K_NS / CLK_PERIOD_NS);
  localparam logic [11:0] MON1M_CYC   = 12'(2 * MON1M_NS / CLK_PERIOD_NS);
  localparam logic [11:0] MON5M_CYC   = 12'(2 * MON5M_NS / CLK_PERIOD_NS);
  // Digit limits: 10us,100us,1ms,10ms,100ms,s,10s,min,10min; hours; days
  localparam logic [35:0] TIME_LOW_MAX = 36'h595999999;
  localparam logic [7:0]  HOURS_MAX    = 8'h23;
  localparam logic [19:0] SUBSEC_MAX   = 20'h99999;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_TIME0   = 8'h10;
  localparam logic [7:0] OFS_TIME1   = 8'h14;
  localparam logic [7:0] OFS_TIME2   = 8'h18;
  localparam logic [7:0] OFS_TIME3   = 8'h1c;
  localparam logic [7:0] OFS_TAG_LO  = 8'h20;
  localparam logic [7:0] OFS_TAG_HI  = 8'h24;
  localparam logic [7:0] OFS_INIT_LO = 8'h28;
  localparam logic [7:0] OFS_INIT_HI = 8'h2c;
  localparam logic [7:0] OFS_INC1_LO = 8'h30;
  localparam logic [7:0] OFS_INC1_HI = 8'h34;
  localparam logic [7:0] OFS_INC2_LO = 8'h38;
  localparam logic [7:0] OFS_INC2_HI = 8'h3c;
  localparam logic [7:0] OFS_OUT_LO  = 8'h40;
  localparam logic [7:0] OFS_OUT_HI  = 8'h44;
  localparam logic [7:0] OFS_CYC_LO  = 8'h48;
  localparam logic [7:0] OFS_CYC_HI  = 8'h4c;
  // Field positions
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned CTRL_PPS_BIT = 1;
  localparam int unsigned TAG_FN_LSB   = 28;
  localparam logic [1:0]  CTRL_RST     = 2'h0;

  typedef enum logic [2:0] {
    FN_NONE, FN_LOAD_STOP, FN_LOAD_INC1, FN_LOAD_INC2,
    FN_INC1, FN_INC2, FN_STOP, FN_STEP
  } srt_func_e;

  // One BCD digit increment with limit; returns {carry, digit}
  function automatic logic [4:0] srt_dig_inc(input logic [3:0] d,
                                             input logic [3:0] mx,
                                             input logic       c);
    if (!c) return {1'b0, d};
    if (d >= mx) return {1'b1, 4'h0};
    return {1'b0, 4'(d + 4'h1)};
  endfunction : srt_dig_inc

  // Advance a day/hour/minute/second/10us time value by one step
  function automatic logic [55:0] srt_time_inc(input logic [55:0] t);
    logic [55:0] r;
    logic [4:0]  s;
    logic        c;
    r = t;
    c = 1'b1;
    for (int i = 0; i < 9; i++) begin
      s = srt_dig_inc(t[i*4 +: 4], TIME_LOW_MAX[i*4 +: 4], c);
      r[i*4 +: 4] = s[3:0];
      c = s[4];
    end
    if (c && t[43:36] >= HOURS_MAX) begin
      r[43:36] = 8'h00;
    end else begin
      s = srt_dig_inc(t[39:36], 4'h9, c);
      r[39:36] = s[3:0];
      s = srt_dig_inc(t[43:40], 4'h9, s[4]);
      r[43:40] = s[3:0];
      c = 1'b0;
    end
    for (int i = 11; i < 14; i++) begin
      s = srt_dig_inc(t[i*4 +: 4], 4'h9, c);
      r[i*4 +: 4] = s[3:0];
      c = s[4];
    end
    return r;
  endfunction : srt_time_inc
endpackage : srt_pkg

// ### design/srt_add_if.sv
// Handshake between the ramp control and the serial BCD adder
`timescale 1ns/100ps
interface srt_add_if;
  logic        start;
  logic [55:0] a;
  logic [55:0] b;
  logic [55:0] sum;
  logic        done;
  modport ctl (output start, output a, output b, input sum, input done);
  modport eng (input start, input a, input b, output sum, output done);
endinterface : srt_add_if

// ### design/srt_bcd_adder.sv
// Digit-serial BCD adder, one digit per clock
`timescale 1ns/100ps
module srt_bcd_adder
  import srt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Operands and result
  srt_add_if.eng   add
);
  logic [55:0] a_q;
  logic [55:0] b_q;
  logic [55:0] sum_q;
  logic [3:0]  idx_q;
  logic        busy_q;
  logic        c_q;
  logic        done_q;

  wire  [4:0]  raw = 5'(a_q[3:0]) + 5'(b_q[3:0]) + 5'(c_q);
  wire         adj = raw > 5'h09;
  wire  [4:0]  dig = adj ? 5'(raw + 5'h06) : raw;

  // 14 digits take 14 clocks, far below one 10 us period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q    <= '0;
      b_q    <= '0;
      sum_q  <= '0;
      idx_q  <= 4'h0;
      busy_q <= 1'b0;
      c_q    <= 1'b0;
      done_q <= 1'b0;
    end else if (add.start) begin
      a_q    <= add.a;
      b_q    <= add.b;
      idx_q  <= 4'h0;
      busy_q <= 1'b1;
      c_q    <= 1'b0;
      done_q <= 1'b0;
    end else if (busy_q) begin
      a_q    <= a_q >> 4;
      b_q    <= b_q >> 4;
      sum_q  <= {dig[3:0], sum_q[55:4]};
      c_q    <= adj;
      idx_q  <= 4'(idx_q + 4'h1);
      busy_q <= idx_q != 4'(NDIG - 1);
      done_q <= idx_q == 4'(NDIG - 1);
    end
  end

  assign add.sum  = sum_q;
  assign add.done = done_q;
endmodule : srt_bcd_adder

// ### design/srt_rtc.sv
// Real-time clock counter: 10 us steps up to 999 days
`timescale 1ns/100ps
module srt_rtc
  import srt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Stepping
  input  wire logic        tick,
  input  wire logic        pps,
  // Parallel preset
  input  wire logic        load,
  input  wire logic [55:0] load_val,
  // Count
  output logic      [55:0] cnt
);
  logic [55:0] cnt_q;
  wire  [55:0] pps_base = {cnt_q[55:20], SUBSEC_MAX};
  wire  [55:0] step_val = srt_time_inc(pps ? pps_base : cnt_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (tick) begin
      cnt_q <= step_val;
    end
  end

  assign cnt = cnt_q;
endmodule : srt_rtc

// ### design/srt_ctrl_top.sv
// Timing, time-tag, frequency ramp and status logic with an APB slave
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module srt_ctrl_top
  import srt_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Timing references
  input  wire logic        REF_100K,
  input  wire logic        ONCE_PER_SECOND_PULSE,
  input  wire logic [55:0] STATION_TIME_SOURCE,
  input  wire logic        STATION_TIME_VALID,
  // Synthesizer monitor
  input  wire logic        SYN_CYCLE,
  input  wire logic        MON_1M,
  input  wire logic        MON_5M,
  input  wire logic        SYN_POWER,
  input  wire logic        SYN_UNLOCK,
  // Frequency command and requests
  output logic      [55:0] FREQ_CMD,
  output logic             TAG_IRQ,
  output logic             TICK_IRQ,
  // Contact closures
  output logic             CC_READY,
  output logic             CC_INLOCK,
  output logic             CC_POWER
);
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [1:0]  ctrl_q;
  logic        ref_q;
  logic        pps_q;
  logic        pps_pend_q;
  logic        tick_q;
  logic [47:0] time_stage_q;
  logic [55:0] tag_time_q;
  srt_func_e   tag_fn_q;
  logic        tag_armed_q;
  logic [55:0] init_q;
  logic [55:0] inc1_q;
  logic [55:0] inc2_q;
  logic [55:0] s1_q;
  logic [55:0] s2_q;
  logic        run_q;
  logic        incsel_q;
  logic        load_pend_q;
  logic        step_pend_q;
  logic        sum_ok_q;
  logic        syn_q;
  logic [35:0] cyc_q;
  logic [35:0] cyc_lat_q;
  logic [11:0] mon_cnt_q [3];
  logic [2:0]  fault_q;
  logic        lost_q;
  logic        tag_irq_q;
  logic        tick_irq_q;
  logic [2:0]  cc_q;
  logic [55:0] rtc_cnt;

  srt_add_if add_bus ();

  // Bus phases and address decode
  wire setup   = PSEL & ~PENABLE;
  wire access  = PSEL & PENABLE & pready_q;
  wire wr_acc  = access & PWRITE;
  wire rd_acc  = access & ~PWRITE;
  wire hit_ctrl  = PADDR == OFS_CTRL;
  wire hit_cmd   = PADDR == OFS_CMD;
  wire hit_stat  = PADDR == OFS_STATUS;
  wire hit_t0    = PADDR == OFS_TIME0;
  wire hit_t1    = PADDR == OFS_TIME1;
  wire hit_t2    = PADDR == OFS_TIME2;
  wire hit_t3    = PADDR == OFS_TIME3;
  wire hit_taglo = PADDR == OFS_TAG_LO;
  wire hit_taghi = PADDR == OFS_TAG_HI;
  wire hit_inilo = PADDR == OFS_INIT_LO;
  wire hit_inihi = PADDR == OFS_INIT_HI;
  wire hit_i1lo  = PADDR == OFS_INC1_LO;
  wire hit_i1hi  = PADDR == OFS_INC1_HI;
  wire hit_i2lo  = PADDR == OFS_INC2_LO;
  wire hit_i2hi  = PADDR == OFS_INC2_HI;
  wire hit_outlo = PADDR == OFS_OUT_LO;
  wire hit_outhi = PADDR == OFS_OUT_HI;
  wire hit_cyclo = PADDR == OFS_CYC_LO;
  wire hit_cychi = PADDR == OFS_CYC_HI;
  wire addr_ok = hit_ctrl | hit_cmd | hit_stat | hit_t0 | hit_t1 | hit_t2 |
                 hit_t3 | hit_taglo | hit_taghi | hit_inilo | hit_inihi |
                 hit_i1lo | hit_i1hi | hit_i2lo | hit_i2hi | hit_outlo |
                 hit_outhi | hit_cyclo | hit_cychi;

  // Time source selection and stepping
  wire tick      = REF_100K & ~ref_q;
  wire pps_rise  = ONCE_PER_SECOND_PULSE & ~pps_q;
  wire pps_go    = tick & pps_pend_q & ctrl_q[CTRL_PPS_BIT];
  wire use_ext   = ctrl_q[CTRL_EXT_BIT] & STATION_TIME_VALID;
  wire time_wr   = wr_acc & hit_t3;
  wire rtc_load  = time_wr | use_ext;
  wire [55:0] rtc_val = time_wr ? {PWDATA[7:0], time_stage_q}
                                : STATION_TIME_SOURCE;
  // Internal count already follows station time, so loss is seamless
  wire [55:0] sel_time = use_ext ? STATION_TIME_SOURCE : rtc_cnt;
  wire bnd_100ms = tick_q & (sel_time[15:0] == 16'h0000);

  // Time tag and function dispatch
  wire tag_match = tag_armed_q & (sel_time == tag_time_q);
  wire cmd_wr    = wr_acc & hit_cmd;
  wire [2:0] cmd_code = cmd_wr ? PWDATA[2:0] : 3'h0;
  wire [2:0] tag_code = tag_match ? tag_fn_q : 3'h0;
  srt_func_e fn;
  assign fn = srt_func_e'(tag_match ? tag_code : cmd_code);
  wire fn_load = fn == FN_LOAD_STOP || fn == FN_LOAD_INC1 ||
                 fn == FN_LOAD_INC2;
  wire fn_run  = fn == FN_LOAD_INC1 || fn == FN_LOAD_INC2 ||
                 fn == FN_INC1 || fn == FN_INC2;
  wire fn_halt = fn == FN_LOAD_STOP || fn == FN_STOP;
  wire fn_sel1 = fn == FN_LOAD_INC1 || fn == FN_INC1;
  wire fn_sel2 = fn == FN_LOAD_INC2 || fn == FN_INC2;
  wire fn_step = fn == FN_STEP;
  wire incsel_d = fn_sel2 ? 1'b1 : (fn_sel1 ? 1'b0 : incsel_q);
  wire add_now  = (run_q | step_pend_q) & sum_ok_q;

  // Adder is restarted after each step and after each function
  assign add_bus.start = tick_q | (fn != FN_NONE);
  assign add_bus.a     = s1_q;
  assign add_bus.b     = incsel_d ? inc2_q : inc1_q;

  // Cycle counter next value and monitor inputs
  wire syn_rise = SYN_CYCLE & ~syn_q;
  logic [35:0] cyc_d;
  logic [4:0]  cyc_s;
  always_comb begin
    cyc_s = {syn_rise, 4'h0};
    cyc_d = cyc_q;
    for (int i = 0; i < 9; i++) begin
      cyc_s = srt_dig_inc(cyc_q[i*4 +: 4], 4'h9, cyc_s[4]);
      cyc_d[i*4 +: 4] = cyc_s[3:0];
    end
  end
  wire [2:0]  mon_in    = {MON_5M, MON_1M, REF_100K};
  logic [2:0] mon_prev_q;
  wire [2:0]  mon_rise  = mon_in & ~mon_prev_q;
  wire [11:0] mon_lim [3] = '{MON100K_CYC, MON1M_CYC, MON5M_CYC};

  wire stat_rd  = rd_acc & hit_stat;
  wire lost_d   = SYN_UNLOCK | (lost_q & ~(stat_rd & prdata_q[5]));
  wire [31:0] status_w = {22'h0, STATION_TIME_VALID, tag_armed_q, incsel_q,
                          run_q, lost_q, SYN_UNLOCK, SYN_POWER,
                          fault_q};

  // Read data selection
  wire [31:0] rdata_w =
      hit_ctrl  ? {30'h0, ctrl_q} :
      hit_stat  ? status_w :
      hit_t0    ? {16'h0, sel_time[15:0]} :
      hit_t1    ? {16'h0, sel_time[31:16]} :
      hit_t2    ? {16'h0, sel_time[47:32]} :
      hit_t3    ? {24'h0, sel_time[55:48]} :
      hit_taglo ? tag_time_q[31:0] :
      hit_taghi ? {1'b0, tag_fn_q, 4'h0, tag_time_q[55:32]} :
      hit_inilo ? init_q[31:0] :
      hit_inihi ? {8'h0, init_q[55:32]} :
      hit_i1lo  ? inc1_q[31:0] :
      hit_i1hi  ? {8'h0, inc1_q[55:32]} :
      hit_i2lo  ? inc2_q[31:0] :
      hit_i2hi  ? {8'h0, inc2_q[55:32]} :
      hit_outlo ? s2_q[31:0] :
      hit_outhi ? {8'h0, s2_q[55:32]} :
      hit_cyclo ? cyc_lat_q[31:0] :
      hit_cychi ? {28'h0, cyc_lat_q[35:32]} : 32'h0;

  srt_rtc u_rtc (
    .clk      (CLK_SYS),
    .rst_n    (ARST_N),
    .tick     (tick),
    .pps      (pps_go),
    .load     (rtc_load),
    .load_val (rtc_val),
    .cnt      (rtc_cnt)
  );

  srt_bcd_adder u_add (
    .clk   (CLK_SYS),
    .rst_n (ARST_N),
    .add   (add_bus.eng)
  );

  // APB answer: one wait-free access phase
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~addr_ok;
      if (setup) prdata_q <= PWRITE ? 32'h0 : rdata_w;
    end
  end

  // Software-written registers
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q       <= CTRL_RST;
      time_stage_q <= '0;
      tag_time_q   <= '0;
      init_q       <= '0;
      inc1_q       <= '0;
      inc2_q       <= '0;
    end else if (wr_acc) begin
      if (hit_ctrl)  ctrl_q              <= PWDATA[1:0];
      if (hit_t0)    time_stage_q[15:0]  <= PWDATA[15:0];
      if (hit_t1)    time_stage_q[31:16] <= PWDATA[15:0];
      if (hit_t2)    time_stage_q[47:32] <= PWDATA[15:0];
      if (hit_taglo) tag_time_q[31:0]    <= PWDATA;
      if (hit_taghi) tag_time_q[55:32]   <= PWDATA[23:0];
      if (hit_inilo) init_q[31:0]        <= PWDATA;
      if (hit_inihi) init_q[55:32]       <= PWDATA[23:0];
      if (hit_i1lo)  inc1_q[31:0]        <= PWDATA;
      if (hit_i1hi)  inc1_q[55:32]       <= PWDATA[23:0];
      if (hit_i2lo)  inc2_q[31:0]        <= PWDATA;
      if (hit_i2hi)  inc2_q[55:32]       <= PWDATA[23:0];
    end
  end

  // Tag arming and timing edges
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tag_fn_q    <= FN_NONE;
      tag_armed_q <= 1'b0;
      ref_q       <= 1'b0;
      pps_q       <= 1'b0;
      pps_pend_q  <= 1'b0;
      tick_q      <= 1'b0;
      tag_irq_q   <= 1'b0;
      tick_irq_q  <= 1'b0;
    end else begin
      ref_q      <= REF_100K;
      pps_q      <= ONCE_PER_SECOND_PULSE;
      pps_pend_q <= pps_rise | (pps_pend_q & ~tick);
      tick_q     <= tick;
      tag_irq_q  <= tag_match;
      tick_irq_q <= bnd_100ms;
      if (wr_acc && hit_taghi) begin
        tag_fn_q    <= srt_func_e'(PWDATA[TAG_FN_LSB +: 3]);
        tag_armed_q <= 1'b1;
      end else if (tag_match) begin
        tag_armed_q <= 1'b0;
      end
    end
  end

  // Two-stage output storage
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_q        <= '0;
      s2_q        <= '0;
      run_q       <= 1'b0;
      incsel_q    <= 1'b0;
      load_pend_q <= 1'b0;
      step_pend_q <= 1'b0;
      sum_ok_q    <= 1'b0;
    end else begin
      incsel_q    <= incsel_d;
      run_q       <= fn_run | (run_q & ~fn_halt);
      load_pend_q <= fn_load | (load_pend_q & ~tick);
      step_pend_q <= fn_step | (step_pend_q & ~(tick & sum_ok_q));
      sum_ok_q    <= add_bus.done & ~add_bus.start;
      if (tick) begin
        s2_q <= s1_q;
        if (load_pend_q)  s1_q <= init_q;
        else if (add_now) s1_q <= add_bus.sum;
      end
    end
  end

  // Cycle counter, clock one-shots, lock latch and contacts
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      syn_q      <= 1'b0;
      cyc_q      <= '0;
      cyc_lat_q  <= '0;
      mon_prev_q <= 3'h0;
      mon_cnt_q  <= '{default: 12'h000};
      fault_q    <= 3'h0;
      lost_q     <= 1'b0;
      cc_q       <= 3'h0;
    end else begin
      syn_q      <= SYN_CYCLE;
      cyc_q      <= cyc_d;
      if (bnd_100ms) cyc_lat_q <= cyc_q;
      mon_prev_q <= mon_in;
      for (int i = 0; i < 3; i++) begin
        mon_cnt_q[i] <= mon_rise[i] ? 12'h000 :
                        (fault_q[i] ? mon_cnt_q[i] : 12'(mon_cnt_q[i] + 12'h1));
        fault_q[i]   <= ~mon_rise[i] & (mon_cnt_q[i] >= mon_lim[i]);
      end
      lost_q <= lost_d;
      cc_q   <= {SYN_POWER, ~SYN_UNLOCK,
                 SYN_POWER & ~SYN_UNLOCK & ~|fault_q};
    end
  end

  assign PRDATA    = prdata_q;
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;
  assign FREQ_CMD  = s2_q;
  assign TAG_IRQ   = tag_irq_q;
  assign TICK_IRQ  = tick_irq_q;
  assign CC_READY  = cc_q[0];
  assign CC_INLOCK = cc_q[1];
  assign CC_POWER  = cc_q[2];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  stage_shift_a: assert property (tick |=> s2_q == $past(s1_q))
    else $error("stage two did not take stage one on a step");
  load_init_a: assert property (tick && load_pend_q |=> s1_q == $past(init_q))
    else $error("initial value not loaded into stage one");
  tag_irq_a: assert property (tag_match && !(wr_acc && hit_taghi)
                              |=> TAG_IRQ ##1 !TAG_IRQ)
    else $error("tag match did not give a one-cycle request");
  tag_once_a: assert property (tag_match && !(wr_acc && hit_taghi)
                               |=> !tag_armed_q)
    else $error("tag still armed after match");
  lost_sticky_a: assert property (SYN_UNLOCK
                                  |=> lost_q ##1 (lost_q || $past(stat_rd)))
    else $error("lock-lost flag not held after unlock");
  cyc_latch_a: assert property (bnd_100ms |=> cyc_lat_q == $past(cyc_q))
    else $error("cycle count not latched at boundary");
  ext_track_a: assert property (use_ext && !time_wr
                                |=> rtc_cnt == $past(STATION_TIME_SOURCE))
    else $error("internal clock not following station time");
  stop_halt_a: assert property (fn == FN_STOP |=> !run_q)
    else $error("stop command left the ramp running");
endmodule : srt_ctrl_top

// ### dv/srt_syn_model.sv
// Behavioural synthesizer: reference, monitored clocks, cycles and health
`timescale 1ns/100ps
module srt_syn_model (
  // Test controls
  input  wire logic stop_5m,
  input  wire logic unlock_req,
  // Toward the controller
  output logic      ref_100k,
  output logic      mon_1m,
  output logic      mon_5m,
  output logic      syn_cycle,
  output logic      syn_power,
  output logic      syn_unlock
);
  initial begin
    ref_100k = 1'b0;
    mon_1m = 1'b0;
    mon_5m = 1'b0;
    syn_cycle = 1'b0;
    syn_power = 1'b1;
  end
  // Reference shortened to 40 system cycles to keep the run short
  always #160 ref_100k = ~ref_100k;
  always #500 mon_1m = ~mon_1m;
  always #100 mon_5m = stop_5m ? 1'b0 : ~mon_5m;
  // Half period of five clocks: four cycles per reference period
  always #40 syn_cycle = ~syn_cycle;
  assign syn_unlock = unlock_req;
endmodule : srt_syn_model

// ### dv/srt_ctrl_top_tb.sv
// Self-checking bench for the ramp and time-tag controller
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module srt_ctrl_top_tb;
  import srt_pkg::*;
  logic        clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, perr_s;
  logic        st_ok = 0, unl = 0, stop5 = 0, pps = 0;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic [55:0] st = 0, freq, b;
  logic        prdy, perr, ref100k, m1, m5, cyc, pow, unlk, tirq, tkirq;
  logic        cc_r, cc_l, cc_p;
  int          n_mismatch = 0, cmp_count = 0;
  logic [15:0] lf = 16'h000d;
  longint      f, fi, inc, M = 64'd100000000000000;

  always #4 clk = ~clk;
  srt_syn_model srt_syn_model_i (.stop_5m(stop5), .unlock_req(unl),
    .ref_100k(ref100k), .mon_1m(m1), .mon_5m(m5), .syn_cycle(cyc),
    .syn_power(pow), .syn_unlock(unlk));
  srt_ctrl_top srt_ctrl_top_i (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .REF_100K(ref100k),
    .ONCE_PER_SECOND_PULSE(pps), .STATION_TIME_SOURCE(st),
    .STATION_TIME_VALID(st_ok), .SYN_CYCLE(cyc), .MON_1M(m1), .MON_5M(m5),
    .SYN_POWER(pow), .SYN_UNLOCK(unlk), .FREQ_CMD(freq), .TAG_IRQ(tirq),
    .TICK_IRQ(tkirq), .CC_READY(cc_r), .CC_INLOCK(cc_l), .CC_POWER(cc_p));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [55:0] bcd(input longint v);
    for (int i = 0; i < 14; i++) begin
      bcd[i*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction : bcd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    perr_s = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic w56(input logic [7:0] a, input longint v);
    b = bcd(v);
    apb(1'b1, a, b[31:0]);
    apb(1'b1, a + 8'h04, {8'h00, b[55:32]});
  endtask : w56
  task automatic tk(input int n);
    repeat (n) @(posedge ref100k);
    repeat (20) @(posedge clk);
  endtask : tk
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    lf = lfsr(lf);
    fi = M / 10 * 4 + lf;
    lf = lfsr(lf);
    inc = lf;
    f = fi;
    w56(OFS_INIT_LO, fi);
    apb(1'b0, OFS_INIT_LO, 32'h0);
    `CHK(rd, b[31:0])
    w56(OFS_INC1_LO, inc);
    w56(OFS_INC2_LO, M - 7);
    apb(1'b0, OFS_INC2_HI, 32'h0);
    `CHK(rd, {8'h00, b[55:32]})
    apb(1'b1, OFS_CMD, 32'h2);
    for (int i = 0; i < 4 && freq !== bcd(f); i++) tk(1);
    `CHK(freq, bcd(f))
    for (int i = 0; i < 3; i++) begin
      f = (f + inc) % M;
      tk(1);
      `CHK(freq, bcd(f))
    end
    apb(1'b1, OFS_CMD, 32'h5);
    tk(1);
    f = (f + inc) % M;
    `CHK(freq, bcd(f))
    for (int i = 0; i < 2; i++) begin
      f = (f + M - 7) % M;
      tk(1);
      `CHK(freq, bcd(f))
    end
    apb(1'b1, OFS_CMD, 32'h6);
    tk(3);
    f = (f + M - 7) % M;
    `CHK(freq, bcd(f))
    tk(2);
    `CHK(freq, bcd(f))
    apb(1'b1, OFS_CMD, 32'h7);
    tk(2);
    f = (f + M - 7) % M;
    `CHK(freq, bcd(f))
    $display("ramp test done");
    for (int i = 0; i < 4; i++) apb(1'b1, OFS_TIME0 + 8'(i * 4), 32'h0);
    apb(1'b1, OFS_TAG_LO, 32'h00000050);
    apb(1'b1, OFS_TAG_HI, 32'h10000000);
    @(posedge tirq);
    apb(1'b0, OFS_TIME0, 32'h0);
    `CHK(rd, 32'h00000050)
    tk(2);
    `CHK(freq, bcd(fi))
    $display("tag test done");
    st <= {24'h001122, 16'h2310, 16'h0000};
    st_ok <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_TIME1, 32'h0);
    `CHK(rd, 32'h00002310)
    @(posedge tkirq);
    apb(1'b0, OFS_CYC_LO, 32'h0);
    b = {24'h0, rd};
    @(posedge tkirq);
    apb(1'b0, OFS_CYC_LO, 32'h0);
    `CHK(rd[3:0], 4'((b[3:0] + 4'h4) % 4'ha))
    st_ok <= 1'b0;
    tk(3);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_TIME2, 32'h0);
    `CHK(rd, 32'h00001122)
    apb(1'b1, OFS_CTRL, 32'h2);
    pps <= 1'b1;
    tk(1);
    apb(1'b0, OFS_TIME1, 32'h0);
    `CHK(rd, 32'h00002320)
    $display("time source test done");
    unl <= 1'b1;
    repeat (5) @(posedge clk);
    unl <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[5], rd[3]}, 2'h3)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[5], 1'b0)
    stop5 <= 1'b1;
    repeat (100) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2], 1'b1)
    `CHK({cc_r, cc_l, cc_p}, 3'h3)
    stop5 <= 1'b0;
    apb(1'b0, 8'hfc, 32'h0);
    `CHK({perr_s, rd}, 33'h100000000)
    $display("status test done");
    results();
  end
endmodule : srt_ctrl_top_tb
